// file: src/branch_condition_regs.sv
/*
  Condition flags file, loop count and return address registers of the core,
  updated from a one-cycle core command and reachable by software over APB.
  Assumes the core presents one command per cycle synchronous to CORE_CLK_I,
  with the final sticky overflow summary, and an APB master on the same clock.
*/
//
// Function
// - eight four-bit condition fields in one word
// - word record forms set field 0 from result
// - negative result gives pattern 100
// - positive nonzero result gives pattern 010
// - zero result gives pattern 001
// - field 0 last bit copies sticky overflow
// - double-word record forms never record field 0
// - store-word-conditional also updates field 0
// - index top three bits pick compare field
// - compare sets less bit when A below operand
// - compare sets greater bit when A above
// - compare sets equal bit on match
// - compare copies sticky overflow into field
// - options may decrement loop count, zero wraps
// - branch to count uses whole loop count
// - return address targets, branch-and-link loads it
// - return address readable and writable from GPR
// - low two return address bits ignored
`timescale 1ns/10ps
module branch_condition_regs
  import branch_regs_pkg::*;
#(
  parameter int XLEN = WORD_W
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire core_req_t CORE_REQ_I,
  output branch_ans_t BRANCH_O,
  output logic [31:0] FLAGS_O,
  output logic [31:0] LOOP_COUNT_O,
  output logic [31:0] RET_ADDR_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  // ==========================================================================
  // elaboration check
  // ==========================================================================
  if (XLEN != WORD_W) begin : g_width_check
    $error("branch_condition_regs serves a 32-bit word only");
  end

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] loop_count;
    logic [31:0] ret_addr;
    logic [31:0] prdata;
    branch_ans_t branch;
  } state_t;

  state_t state_reg;
  state_t state_next;

  localparam state_t STATE_RST = '{
    flags: FLAGS_RST,
    loop_count: LOOP_RST,
    ret_addr: RET_RST,
    prdata: 32'h0000_0000,
    branch: '{valid: 1'b0, taken: 1'b0, target: 32'h0000_0000}
  };

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic apb_setup;
  logic apb_write;
  logic addr_hit;
  logic [31:0] byte_mask;

  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_write = PSEL_I && PENABLE_I && PWRITE_I;
  assign addr_hit = (PADDR_I == FLAGS_OFF) || (PADDR_I == LOOP_OFF) ||
                    (PADDR_I == RET_OFF) || (PADDR_I == BRSTAT_OFF);

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign byte_mask[8*b +: 8] = {8{PSTRB_I[b]}};
  end

  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [31:0] mask);
    merge = (old_val & ~mask) | (new_val & mask);
  endfunction

  // top bit of field f sits at word bit 31 - 4f (doc bit 32 + 4f)
  function automatic int field_top(input logic [2:0] f);
    field_top = WORD_W - 1 - FIELD_W * int'(f);
  endfunction

  // ==========================================================================
  // core-side results
  // ==========================================================================
  logic [2:0] record_pat;
  logic cmp_less;
  logic cmp_greater;
  logic cmp_equal;
  logic [3:0] cmp_field;
  logic [31:0] loop_dec;
  logic loop_dec_zero;
  logic cond_bit;
  logic cond_ok;
  logic count_ok;
  logic record_en;
  logic [31:0] ret_target;

  always_comb begin
    // sign and zero test of result bits 32..63
    if (CORE_REQ_I.result[31]) begin
      record_pat = PAT_LESS;
    end else if (CORE_REQ_I.result[30:0] != 31'h0000_0000) begin
      record_pat = PAT_GREATER;
    end else begin
      record_pat = PAT_ZERO;
    end
  end

  always_comb begin
    if (CORE_REQ_I.unsigned_cmp) begin
      cmp_less = CORE_REQ_I.source_a < CORE_REQ_I.source_b;
      cmp_greater = CORE_REQ_I.source_a > CORE_REQ_I.source_b;
    end else begin
      cmp_less = $signed(CORE_REQ_I.source_a) < $signed(CORE_REQ_I.source_b);
      cmp_greater = $signed(CORE_REQ_I.source_a) > $signed(CORE_REQ_I.source_b);
    end
    cmp_equal = CORE_REQ_I.source_a == CORE_REQ_I.source_b;
    cmp_field = {cmp_less, cmp_greater, cmp_equal,
                 CORE_REQ_I.sticky_overflow_summary};
  end

  // word operations only; double-word forms leave field 0 alone
  assign record_en = CORE_REQ_I.record_flag && !CORE_REQ_I.double_word;

  // zero minus one wraps to all ones
  assign loop_dec = state_reg.loop_count - 32'h0000_0001;
  assign loop_dec_zero = loop_dec == 32'h0000_0000;

  // flag bit selected by the full five-bit index
  assign cond_bit = state_reg.flags[WORD_W - 1 - int'(CORE_REQ_I.condition_index_field)];
  assign cond_ok = CORE_REQ_I.branch_options_field[OPT_NO_COND] ||
                   (cond_bit == CORE_REQ_I.branch_options_field[OPT_COND_TRUE]);
  assign count_ok = CORE_REQ_I.branch_options_field[OPT_NO_DEC] ||
                    (loop_dec_zero == CORE_REQ_I.branch_options_field[OPT_COUNT_ZERO]);

  assign ret_target = {state_reg.ret_addr[31:2], 2'h0};

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    state_next.branch.valid = 1'b0;
    state_next.branch.taken = 1'b0;

    // read data captured in the setup cycle, shown in the access cycle
    if (apb_setup) begin
      case (PADDR_I)
        FLAGS_OFF: begin
          state_next.prdata = state_reg.flags;
        end
        LOOP_OFF: begin
          state_next.prdata = state_reg.loop_count;
        end
        RET_OFF: begin
          state_next.prdata = state_reg.ret_addr;
        end
        BRSTAT_OFF: begin
          state_next.prdata = 32'h0000_0000;
          state_next.prdata[BRSTAT_TAKEN] = state_reg.branch.taken;
          state_next.prdata[BRSTAT_VALID] = state_reg.branch.valid;
        end
        default: begin
          state_next.prdata = 32'h0000_0000;
        end
      endcase
    end

    // software writes first, so a core update in the same cycle wins
    if (apb_write) begin
      case (PADDR_I)
        FLAGS_OFF: begin
          state_next.flags = merge(state_reg.flags, PWDATA_I, byte_mask);
        end
        LOOP_OFF: begin
          state_next.loop_count = merge(state_reg.loop_count, PWDATA_I, byte_mask);
        end
        RET_OFF: begin
          state_next.ret_addr = merge(state_reg.ret_addr, PWDATA_I, byte_mask);
        end
        default: begin
        end
      endcase
    end

    case (CORE_REQ_I.op)
      OP_RECORD: begin
        if (record_en) begin
          state_next.flags[31:28] = {record_pat,
                                     CORE_REQ_I.sticky_overflow_summary};
        end
      end
      OP_STORE_COND: begin
        state_next.flags[31:28] = {CORE_REQ_I.store_cond_flags,
                                   CORE_REQ_I.sticky_overflow_summary};
      end
      OP_COMPARE: begin
        // upper three index bits name the field, all four bits are written
        state_next.flags[field_top(CORE_REQ_I.condition_index_field[4:2]) -: FIELD_W]
          = cmp_field;
      end
      OP_BRANCH: begin
        if (!CORE_REQ_I.branch_options_field[OPT_NO_DEC]) begin
          state_next.loop_count = loop_dec;
        end
        if (CORE_REQ_I.link) begin
          state_next.ret_addr = CORE_REQ_I.return_addr;
        end
        state_next.branch.valid = 1'b1;
        state_next.branch.taken = cond_ok && count_ok;
        case (CORE_REQ_I.target_sel)
          TGT_RETURN: begin
            state_next.branch.target = ret_target;
          end
          TGT_COUNT: begin
            state_next.branch.target = state_reg.loop_count;
          end
          default: begin
            state_next.branch.target = CORE_REQ_I.direct_target;
          end
        endcase
      end
      OP_WRITE_RET: begin
        state_next.ret_addr = CORE_REQ_I.gpr_data;
      end
      OP_WRITE_LOOP: begin
        state_next.loop_count = CORE_REQ_I.gpr_data;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign BRANCH_O = state_reg.branch;
  assign FLAGS_O = state_reg.flags;
  assign LOOP_COUNT_O = state_reg.loop_count;
  assign RET_ADDR_O = state_reg.ret_addr;
  assign PRDATA_O = state_reg.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

endmodule

// file: src/branch_regs_pkg.sv
/*
  Package for the condition and branch register block: APB offsets, field
  layout, reset values, core command encodings and request/answer carriers.
  Assumes a 32-bit core whose bit 32 is the most significant bit of a word.
*/
package branch_regs_pkg;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [11:0] FLAGS_OFF = 12'h000;
  localparam logic [11:0] LOOP_OFF = 12'h004;
  localparam logic [11:0] RET_OFF = 12'h008;
  localparam logic [11:0] BRSTAT_OFF = 12'h00c;
  localparam int ADDR_W = 12;

  // ==========================================================================
  // widths, layout and reset values
  // ==========================================================================
  localparam int WORD_W = 32;
  localparam int FIELD_W = 4;
  localparam int NUM_FIELDS = 8;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] LOOP_RST = 32'h0000_0000;
  localparam logic [31:0] RET_RST = 32'h0000_0000;
  // bit positions within one field, counted from its bottom bit
  localparam int LESS_POS = 3;
  localparam int GREATER_POS = 2;
  localparam int ZERO_POS = 1;
  localparam int OVF_POS = 0;
  localparam logic [2:0] PAT_LESS = 3'h4;
  localparam logic [2:0] PAT_GREATER = 3'h2;
  localparam logic [2:0] PAT_ZERO = 3'h1;
  // branch options field bits, top bit first
  localparam int OPT_NO_COND = 4;
  localparam int OPT_COND_TRUE = 3;
  localparam int OPT_NO_DEC = 2;
  localparam int OPT_COUNT_ZERO = 1;
  localparam logic [1:0] TGT_DIRECT = 2'h0;
  localparam logic [1:0] TGT_RETURN = 2'h1;
  localparam logic [1:0] TGT_COUNT = 2'h2;
  // branch status register layout
  localparam int BRSTAT_TAKEN = 0;
  localparam int BRSTAT_VALID = 1;

  // ==========================================================================
  // core commands
  // ==========================================================================
  typedef enum logic [6:0] {
    OP_NONE = 7'h01,
    OP_RECORD = 7'h02,
    OP_STORE_COND = 7'h04,
    OP_COMPARE = 7'h08,
    OP_BRANCH = 7'h10,
    OP_WRITE_RET = 7'h20,
    OP_WRITE_LOOP = 7'h40
  } core_op_t;

  typedef struct packed {
    core_op_t op;
    logic double_word;
    logic record_flag;
    logic [31:0] result;
    logic [31:0] source_a;
    logic [31:0] source_b;
    logic unsigned_cmp;
    logic [4:0] condition_index_field;
    logic [4:0] branch_options_field;
    logic [1:0] target_sel;
    logic link;
    logic [31:0] direct_target;
    logic [31:0] return_addr;
    logic [31:0] gpr_data;
    logic sticky_overflow_summary;
    logic [2:0] store_cond_flags;
  } core_req_t;

  typedef struct packed {
    logic valid;
    logic taken;
    logic [31:0] target;
  } branch_ans_t;

endpackage

// file: verification/branch_regs_chk.sv
/*
  Checker for the condition and branch register block.
  Sees only the top ports; bound into the design at the foot of this file.
*/
`timescale 1ns/10ps
module branch_regs_chk
  import branch_regs_pkg::*;
(
  input logic CORE_CLK_I,
  input logic RST_I,
  input core_req_t CORE_REQ_I,
  input branch_ans_t BRANCH_O,
  input logic [31:0] FLAGS_O,
  input logic [31:0] LOOP_COUNT_O,
  input logic [31:0] RET_ADDR_O,
  input logic PSEL_I,
  input logic PENABLE_I,
  input logic PWRITE_I
);
  // ==========================================================================
  // helpers
  // ==========================================================================
  core_req_t r;
  logic rec, lt, gt, apbw, sure;
  logic [3:0] cmp_exp;
  assign r = CORE_REQ_I;
  assign rec = r.op == OP_RECORD && !r.double_word && r.record_flag;
  assign apbw = PSEL_I && PENABLE_I && PWRITE_I;
  // branch that is taken whatever the flags and count say
  assign sure = r.op == OP_BRANCH && r.branch_options_field[OPT_NO_COND]
    && r.branch_options_field[OPT_NO_DEC];
  assign lt = r.unsigned_cmp ? r.source_a < r.source_b
    : $signed(r.source_a) < $signed(r.source_b);
  assign gt = r.unsigned_cmp ? r.source_a > r.source_b
    : $signed(r.source_a) > $signed(r.source_b);
  assign cmp_exp = {lt, gt, r.source_a == r.source_b, r.sticky_overflow_summary};
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  // ==========================================================================
  // assertions
  // ==========================================================================
  rec_neg_a: assert property (
    rec && r.result[31] |=> FLAGS_O[31:28] == {PAT_LESS, $past(r.sticky_overflow_summary)})
    else $error("negative record field wrong");
  rec_pos_a: assert property (
    rec && !r.result[31] && |r.result[30:0] |=> FLAGS_O[31:29] == PAT_GREATER)
    else $error("positive record field wrong");
  rec_zero_a: assert property (
    rec && r.result == 32'h0 |=> FLAGS_O[31:29] == PAT_ZERO)
    else $error("zero record field wrong");
  dword_skip_a: assert property (
    r.op == OP_RECORD && (r.double_word || !r.record_flag) && !apbw |=> $stable(FLAGS_O))
    else $error("unrecorded result changed flags");
  store_cond_a: assert property (
    r.op == OP_STORE_COND |=> FLAGS_O[31:28] ==
      {$past(r.store_cond_flags), $past(r.sticky_overflow_summary)})
    else $error("store conditional field wrong");
  cmp_field_a: assert property (
    r.op == OP_COMPARE |=>
      FLAGS_O[31 - 4 * $past(r.condition_index_field[4:2]) -: 4] == $past(cmp_exp))
    else $error("compare field wrong");
  loop_dec_a: assert property (
    r.op == OP_BRANCH && !r.branch_options_field[OPT_NO_DEC] |=>
      LOOP_COUNT_O == $past(LOOP_COUNT_O) - 32'h1)
    else $error("loop count decrement wrong");
  count_tgt_a: assert property (
    sure && r.target_sel == TGT_COUNT |=>
      BRANCH_O.valid && BRANCH_O.taken && BRANCH_O.target == $past(LOOP_COUNT_O))
    else $error("count target wrong");
  ret_tgt_a: assert property (
    sure && r.target_sel == TGT_RETURN |=>
      BRANCH_O.valid && BRANCH_O.target == {$past(RET_ADDR_O[31:2]), 2'b00})
    else $error("return target wrong");
  link_load_a: assert property (
    sure && r.link |=> RET_ADDR_O == $past(r.return_addr))
    else $error("link did not load return address");
  ret_write_a: assert property (
    r.op == OP_WRITE_RET |=> RET_ADDR_O == $past(r.gpr_data))
    else $error("return address write lost");

  cover property (r.op == OP_COMPARE && r.unsigned_cmp);
  cover property (rec && r.result[31]);
  cover property (r.op == OP_BRANCH && LOOP_COUNT_O == 32'h0 ##1 LOOP_COUNT_O == 32'hffffffff);
endmodule

bind branch_condition_regs branch_regs_chk branch_regs_chk_i (.CORE_CLK_I(CORE_CLK_I),
  .RST_I(RST_I), .CORE_REQ_I(CORE_REQ_I), .BRANCH_O(BRANCH_O), .FLAGS_O(FLAGS_O),
  .LOOP_COUNT_O(LOOP_COUNT_O), .RET_ADDR_O(RET_ADDR_O), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I));

// file: verification/tb.sv
/*
  Self-checking bench for the condition and branch register block.
  Drives core commands and APB directly; the checker is bound separately.
*/
`timescale 1ns/10ps
module tb
  import branch_regs_pkg::*;
;
  typedef struct {
    logic cmp;
    logic uns;
    logic so;
    logic [4:0] idx;
    logic [31:0] a;
    logic [31:0] b;
    logic [3:0] exp;
  } row_t;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, q, ef, flags, loop_cnt, ret, prdata;
  core_req_t req, c, k;
  branch_ans_t br;
  row_t rows [8];
  row_t w;
  int n_errors = 0, compares = 0;

  branch_condition_regs branch_condition_regs_i (.CORE_CLK_I(clk), .RST_I(rst),
    .CORE_REQ_I(req), .BRANCH_O(br), .FLAGS_O(flags), .LOOP_COUNT_O(loop_cnt),
    .RET_ADDR_O(ret), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input core_req_t x);
    @(posedge clk);
    req <= x;
    @(posedge clk);
    req <= c;
    #1;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends at the first edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    c = '0;
    c.op = OP_NONE;
    req = c;
    ef = FLAGS_RST;
    rows[0] = '{1'b0, 1'b0, 1'b1, 5'h00, 32'h80000000, 32'h0, 4'h9};
    rows[1] = '{1'b0, 1'b0, 1'b0, 5'h00, 32'h00000001, 32'h0, 4'h4};
    rows[2] = '{1'b0, 1'b0, 1'b1, 5'h00, 32'h00000000, 32'h0, 4'h3};
    rows[3] = '{1'b0, 1'b0, 1'b0, 5'h00, 32'h7fffffff, 32'h0, 4'h4};
    rows[4] = '{1'b1, 1'b0, 1'b0, 5'h08, 32'hffffffff, 32'h1, 4'h8};
    rows[5] = '{1'b1, 1'b1, 1'b1, 5'h1c, 32'hffffffff, 32'h1, 4'h5};
    rows[6] = '{1'b1, 1'b0, 1'b0, 5'h07, 32'h00000005, 32'h5, 4'h2};
    rows[7] = '{1'b1, 1'b0, 1'b0, 5'h0c, 32'h00000001, 32'h80000000, 4'h4};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(flags, FLAGS_RST);
    chk(loop_cnt, LOOP_RST);
    chk(ret, RET_RST);
    $display("reset test done");
    foreach (rows[i]) begin
      w = rows[i];
      k = c;
      k.op = w.cmp ? OP_COMPARE : OP_RECORD;
      k.record_flag = 1'b1;
      k.result = w.a;
      k.source_a = w.a;
      k.source_b = w.b;
      k.unsigned_cmp = w.uns;
      k.condition_index_field = w.idx;
      k.sticky_overflow_summary = w.so;
      cmd(k);
      ef[31 - 4 * w.idx[4:2] -: 4] = w.exp;
      chk(flags, ef);
    end
    apb(1'b0, FLAGS_OFF, 32'h0);
    chk(q, ef);
    $display("row test done");
    k = c;
    k.op = OP_RECORD;
    k.double_word = 1'b1;
    k.record_flag = 1'b1;
    cmd(k);
    chk(flags, ef);
    k = c;
    k.op = OP_STORE_COND;
    k.store_cond_flags = 3'h1;
    k.sticky_overflow_summary = 1'b1;
    cmd(k);
    ef[31:28] = 4'h3;
    chk(flags, ef);
    $display("field zero test done");
    apb(1'b1, LOOP_OFF, 32'h1234);
    k = c;
    k.op = OP_BRANCH;
    k.branch_options_field = 5'h14;
    k.target_sel = TGT_COUNT;
    cmd(k);
    chk(br.target, 32'h1234);
    chk(loop_cnt, 32'h1234);
    apb(1'b1, LOOP_OFF, 32'h0);
    k.branch_options_field = 5'h10;
    cmd(k);
    chk(loop_cnt, 32'hffffffff);
    chk({31'h0, br.taken}, 32'h1);
    chk({31'h0, br.valid}, 32'h1);
    k = c;
    k.op = OP_WRITE_LOOP;
    k.gpr_data = 32'h1;
    cmd(k);
    chk(loop_cnt, 32'h1);
    // condition test on field 0 less bit, which is clear here
    k.op = OP_BRANCH;
    k.branch_options_field = 5'h02;
    k.condition_index_field = 5'h00;
    k.target_sel = TGT_DIRECT;
    k.direct_target = 32'h100;
    cmd(k);
    chk(loop_cnt, 32'h0);
    chk({31'h0, br.taken}, 32'h1);
    chk(br.target, 32'h100);
    cmd(k);
    chk(loop_cnt, 32'hffffffff);
    chk({31'h0, br.taken}, 32'h0);
    $display("loop count test done");
    k = c;
    k.op = OP_WRITE_RET;
    k.gpr_data = 32'h4003;
    cmd(k);
    apb(1'b0, RET_OFF, 32'h0);
    chk(q, 32'h4003);
    k.op = OP_BRANCH;
    k.branch_options_field = 5'h14;
    k.target_sel = TGT_RETURN;
    k.link = 1'b1;
    k.return_addr = 32'h8000;
    cmd(k);
    chk(br.target, 32'h4000);
    chk(ret, 32'h8000);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    $display("return address test done");
    // reset in mid-run clears every register
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk(flags, FLAGS_RST);
    chk(loop_cnt, LOOP_RST);
    chk(ret, RET_RST);
    chk({31'h0, br.valid}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    k = c;
    k.op = OP_STORE_COND;
    k.store_cond_flags = 3'h4;
    cmd(k);
    chk(flags, 32'h8000_0000);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
